/* File: logic/ucp_top.sv */
// Pin-level logic of a two-channel serial port
`timescale 1ns/1ps
module ucp_top #(
   parameter int TX_THRESH = 1,    // Free slots needed for ready
   parameter int RX_THRESH = 1,    // Bytes needed for receive ready
   parameter int DIV_W     = 16    // Baud divisor width
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  channel_select_in,
   input  wire logic                  wr_in,
   input  wire logic [2:0]            addr_in,
   input  wire logic [7:0]            wdata_in,
   input  wire logic [DIV_W-1:0]      baud_div_in,
   input  wire ucp_pkg::ucp_core_s    core_a_in,
   input  wire ucp_pkg::ucp_core_s    core_b_in,
   input  wire ucp_pkg::ucp_modem_in_s modem_a_in,
   input  wire ucp_pkg::ucp_modem_in_s modem_b_in,
   input  wire logic                  serial_in_a,
   input  wire logic                  serial_in_b,
   output logic                       irq_out_a,
   output logic                       irq_out_b,
   output logic                       tx_ready_n_a,
   output logic                       tx_ready_n_b,
   output logic                       serial_out_a,
   output logic                       serial_out_b,
   output logic                       rx_data_a_out,
   output logic                       rx_data_b_out,
   output logic                       request_to_send_n_a,
   output logic                       request_to_send_n_b,
   output logic                       terminal_ready_n_a,
   output logic                       terminal_ready_n_b,
   output logic                       multi_function_out_a,
   output logic                       multi_function_out_b,
   output logic                       tx_allow_a_out,
   output logic                       tx_allow_b_out,
   output logic                       cts_irq_a_out,
   output logic                       cts_irq_b_out,
   output ucp_pkg::ucp_modem_in_s     gpio_in_a_out,
   output ucp_pkg::ucp_modem_in_s     gpio_in_b_out
);
   import ucp_pkg::*;

   // -----------------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------------
   initial begin
      if (TX_THRESH < 1 || TX_THRESH > 255 || RX_THRESH < 1 ||
          RX_THRESH > 255 || DIV_W < 2) begin
         $error("ucp_top: unsupported parameter value");
      end
   end

   // -----------------------------------------------------------------
   // Control registers, one set per channel (index 0 is A)
   // -----------------------------------------------------------------
   logic [7:0] mcr_ff  [2];   // modem_control_reg
   logic [7:0] feature_control_reg_ff [2];   // feature_control_reg
   logic [7:0] efr_ff  [2];   // enhanced_feature_reg
   logic [7:0] ier_ff  [2];   // irq_enable_reg
   logic [7:0] afr_ff  [2];   // alternate_function_reg
   logic [1:0] wsel;          // Channels hit by this write
   logic       bcast;         // Broadcast active on any channel

   // A write reaches both channels when either broadcast bit is set
   assign bcast = afr_ff[0][AFR_BCAST_BIT] | afr_ff[1][AFR_BCAST_BIT];
   // Select line high picks A, low picks B; broadcast overrides it
   always_comb begin
      wsel = 2'b00;
      if (!cs_n_in && wr_in) begin
         if (bcast) begin
            wsel = 2'b11;
         end else if (channel_select_in) begin
            wsel = 2'b01;
         end else begin
            wsel = 2'b10;
         end
      end
   end

   // Register storage; reset clears every bit including OP2 control
   for (genvar c = 0; c < 2; c++) begin : g_reg
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mcr_ff[c]  <= MCR_RESET;
            feature_control_reg_ff[c] <= FEATURE_CONTROL_REG_RESET;
            efr_ff[c]  <= EFR_RESET;
            ier_ff[c]  <= IER_RESET;
            afr_ff[c]  <= AFR_RESET;
         end else if (wsel[c]) begin
            if (addr_in == IDX_MCR) begin
               mcr_ff[c] <= wdata_in;
            end else if (addr_in == IDX_FEATURE_CONTROL_REG) begin
               feature_control_reg_ff[c] <= wdata_in;
            end else if (addr_in == IDX_EFR) begin
               efr_ff[c] <= wdata_in;
            end else if (addr_in == IDX_IER) begin
               ier_ff[c] <= wdata_in;
            end else if (addr_in == IDX_AFR) begin
               afr_ff[c] <= wdata_in;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Per-channel datapath helpers
   // -----------------------------------------------------------------
   ucp_core_s     core  [2];
   ucp_modem_in_s modem [2];
   logic          sin   [2];
   logic          baud  [2];   // Sixteen-times clock
   logic          irtx  [2];   // Encoded infrared transmit
   logic          irrx  [2];   // Decoded infrared receive
   assign core[0]  = core_a_in;
   assign core[1]  = core_b_in;
   assign modem[0] = modem_a_in;
   assign modem[1] = modem_b_in;
   assign sin[0]   = serial_in_a;
   assign sin[1]   = serial_in_b;

   for (genvar c = 0; c < 2; c++) begin : g_ch
      // Baud clock source for the multi-function pin
      ucp_baud_gen #(.W(DIV_W)) u_baud (
         .clk_in   (clk_in),
         .rst_n_in (rst_n_in),
         .div_in   (baud_div_in),
         .baud_out (baud[c])
      );
      // Infrared path, receive polarity from the feature register
      ucp_ir_codec u_ir (
         .clk_in    (clk_in),
         .rst_n_in  (rst_n_in),
         .tx_bit_in (core[c].tx_bit),
         .rx_pin_in (sin[c]),
         .invert_in (feature_control_reg_ff[c][FEATURE_CONTROL_REG_RXINV_BIT]),
         .ir_tx_out (irtx[c]),
         .ir_rx_out (irrx[c])
      );
   end

   // -----------------------------------------------------------------
   // Next-state values of the pins
   // -----------------------------------------------------------------
   logic [1:0] nxt_irq, nxt_txr_n, nxt_tx, nxt_rx, nxt_rts_n;
   logic [1:0] nxt_dtr_n, nxt_mf, nxt_allow, nxt_ctsirq;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         nxt_irq[c]   = core[c].irq_pend;
         nxt_txr_n[c] = ~(core[c].tx_level >= 8'(TX_THRESH));
         // Standard idles high, infrared idles low
         if (mcr_ff[c][MCR_IR_BIT]) begin
            nxt_tx[c] = irtx[c];
            nxt_rx[c] = irrx[c];
         end else begin
            nxt_tx[c] = core[c].tx_busy ? core[c].tx_bit : 1'b1;
            nxt_rx[c] = sin[c];    // Relies on line idling high
         end
         // RS-485 mode: RTS low only while a frame is being sent
         if (feature_control_reg_ff[c][FEATURE_CONTROL_REG_RS485_BIT]) begin
            nxt_rts_n[c] = ~core[c].tx_busy;
         end else begin
            nxt_rts_n[c] = ~mcr_ff[c][MCR_RTS_BIT];
         end
         nxt_dtr_n[c]  = ~mcr_ff[c][0];
         // CTS high blocks the transmitter in auto mode
         nxt_allow[c]  = ~efr_ff[c][EFR_ACTS_BIT] | ~modem[c].cts_n;
         nxt_ctsirq[c] = efr_ff[c][EFR_ACTS_BIT] &
                         ier_ff[c][IER_CTS_BIT] & modem[c].cts_n;
         case (ucp_mf_e'(afr_ff[c][AFR_MF_LO +: 2]))
            UCP_MF_OP2:   nxt_mf[c] = ~mcr_ff[c][MCR_OP2_BIT];
            UCP_MF_BAUD:  nxt_mf[c] = baud[c];
            UCP_MF_RXRDY: nxt_mf[c] =
               ~(core[c].rx_level >= 8'(RX_THRESH));
            default:      nxt_mf[c] = 1'b1;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Output flip-flops
   // -----------------------------------------------------------------
   logic [1:0] irq_ff, txr_n_ff, tx_ff, rx_ff, rts_n_ff;
   logic [1:0] dtr_n_ff, mf_ff, allow_ff, ctsirq_ff;
   ucp_modem_in_s gpio_ff [2];   // Registered modem inputs as GPIO
   // Reset drives every pin to its idle level
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_ff    <= 2'h0;
         txr_n_ff  <= 2'h3;
         tx_ff     <= 2'h3;
         rx_ff     <= 2'h3;
         rts_n_ff  <= 2'h3;
         dtr_n_ff  <= 2'h3;
         mf_ff     <= 2'h3;
         allow_ff  <= 2'h3;
         ctsirq_ff <= 2'h0;
      end else begin
         irq_ff    <= nxt_irq;
         txr_n_ff  <= nxt_txr_n;
         tx_ff     <= nxt_tx;
         rx_ff     <= nxt_rx;
         rts_n_ff  <= nxt_rts_n;
         dtr_n_ff  <= nxt_dtr_n;
         mf_ff     <= nxt_mf;
         allow_ff  <= nxt_allow;
         ctsirq_ff <= nxt_ctsirq;
      end
   end
   // Modem inputs sampled so software sees them as general input
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gpio_ff[0] <= 4'hF;
         gpio_ff[1] <= 4'hF;
      end else begin
         gpio_ff[0] <= modem[0];
         gpio_ff[1] <= modem[1];
      end
   end

   assign irq_out_a            = irq_ff[0];
   assign irq_out_b            = irq_ff[1];
   assign tx_ready_n_a         = txr_n_ff[0];
   assign tx_ready_n_b         = txr_n_ff[1];
   assign serial_out_a         = tx_ff[0];
   assign serial_out_b         = tx_ff[1];
   assign rx_data_a_out        = rx_ff[0];
   assign rx_data_b_out        = rx_ff[1];
   assign request_to_send_n_a  = rts_n_ff[0];
   assign request_to_send_n_b  = rts_n_ff[1];
   assign terminal_ready_n_a   = dtr_n_ff[0];
   assign terminal_ready_n_b   = dtr_n_ff[1];
   assign multi_function_out_a = mf_ff[0];
   assign multi_function_out_b = mf_ff[1];
   assign tx_allow_a_out       = allow_ff[0];
   assign tx_allow_b_out       = allow_ff[1];
   assign cts_irq_a_out        = ctsirq_ff[0];
   assign cts_irq_b_out        = ctsirq_ff[1];
   assign gpio_in_a_out        = gpio_ff[0];
   assign gpio_in_b_out        = gpio_ff[1];

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   AST_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      irq_out_a == $past(core_a_in.irq_pend))
      else $error("irq A does not follow pending");
   AST_TXRDY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tx_ready_n_b == ($past(core_b_in.tx_level) < 8'(TX_THRESH)))
      else $error("tx ready B wrong");
   AST_STD_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !mcr_ff[0][MCR_IR_BIT] && !core_a_in.tx_busy |=> serial_out_a)
      else $error("standard idle not high");
   AST_IR_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mcr_ff[0][MCR_IR_BIT] && !irtx[0] |=> !serial_out_a)
      else $error("infrared idle not low");
   AST_RS485: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      feature_control_reg_ff[1][FEATURE_CONTROL_REG_RS485_BIT] && core_b_in.tx_busy
      |=> !request_to_send_n_b)
      else $error("rs485 direction not asserted");
   AST_CTS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      efr_ff[0][EFR_ACTS_BIT] && modem_a_in.cts_n |=> !tx_allow_a_out)
      else $error("cts did not stop transmit");
   AST_OP2: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      afr_ff[0][2:1] == 2'h0 |=>
      multi_function_out_a == !$past(mcr_ff[0][MCR_OP2_BIT]))
      else $error("general output level wrong");
   AST_BCAST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bcast && !cs_n_in && wr_in && addr_in == IDX_MCR
      |=> mcr_ff[0] == mcr_ff[1])
      else $error("broadcast missed a channel");
   AST_SEL_B: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !bcast && !cs_n_in && wr_in && !channel_select_in &&
      addr_in == IDX_MCR |=> $stable(mcr_ff[0]))
      else $error("channel B write touched A");
endmodule

/* File: logic/ucp_pkg.sv */
// Package with shared constants and carriers for the dual channel pin logic
package ucp_pkg;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int MCR_RTS_BIT    = 1;   // Request-to-send control
   localparam int MCR_OP2_BIT    = 3;   // General output control
   localparam int MCR_IR_BIT     = 6;   // Infrared enable
   localparam int FEATURE_CONTROL_REG_RXINV_BIT = 2;   // Infrared receive inversion
   localparam int FEATURE_CONTROL_REG_RS485_BIT = 3;   // RS-485 direction control
   localparam int EFR_ARTS_BIT   = 6;   // Auto RTS enable
   localparam int EFR_ACTS_BIT   = 7;   // Auto CTS enable
   localparam int IER_CTS_BIT    = 7;   // CTS interrupt enable
   localparam int AFR_BCAST_BIT  = 0;   // Write both channels at once
   localparam int AFR_MF_LO      = 1;   // Multi-function select low bit

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] MCR_RESET  = 8'h00;
   localparam logic [7:0] FEATURE_CONTROL_REG_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET  = 8'h00;
   localparam logic [7:0] IER_RESET  = 8'h00;
   localparam logic [7:0] AFR_RESET  = 8'h00;

   // -----------------------------------------------------------------
   // Register indices on the parallel side
   // -----------------------------------------------------------------
   localparam logic [2:0] IDX_IER  = 3'h1;
   localparam logic [2:0] IDX_FEATURE_CONTROL_REG = 3'h2;
   localparam logic [2:0] IDX_MCR  = 3'h4;
   localparam logic [2:0] IDX_EFR  = 3'h5;
   localparam logic [2:0] IDX_AFR  = 3'h6;

   // Baud clock divider default (16x clock every N system clocks)
   localparam int BAUD_DIV_RESET = 16'h000A;
   localparam int IR_PULSE_CYC   = 3;   // Infrared pulse length, cycles

   // Multi-function output selection
   typedef enum logic [1:0] {
      UCP_MF_OP2  = 2'h0,
      UCP_MF_BAUD = 2'h1,
      UCP_MF_RXRDY = 2'h2
   } ucp_mf_e;

   // Modem lines of one channel
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic cd_n;
      logic ri_n;
   } ucp_modem_in_s;

   // Per-channel core status from the datapath
   typedef struct packed {
      logic       irq_pend;   // Pending service request
      logic [7:0] tx_level;   // Free slots in transmit FIFO
      logic [7:0] rx_level;   // Bytes in receive FIFO
      logic       tx_busy;    // Transmitter shifting a frame
      logic       tx_bit;     // Serial bit from the shifter
   } ucp_core_s;
endpackage

/* File: logic/ucp_baud_gen.sv */
// Sixteen-times baud clock generator for one channel
`timescale 1ns/1ps
module ucp_baud_gen #(
   parameter int W = 16
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] div_in,
   output logic              baud_out
);
   import ucp_pkg::*;
   // -----------------------------------------------------------------
   // Divider
   // -----------------------------------------------------------------
   logic [W-1:0] cnt_ff;   // Cycle count inside half period
   // Toggle at each half period; a divisor of 0 or 1 holds the clock low
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_ff   <= '0;
         baud_out <= 1'b0;
      end else if (div_in < W'(2)) begin
         cnt_ff   <= '0;
         baud_out <= 1'b0;
      end else if (cnt_ff >= W'(div_in >> 1) - W'(1)) begin
         cnt_ff   <= '0;
         baud_out <= ~baud_out;
      end else begin
         cnt_ff   <= cnt_ff + W'(1);
      end
   end
endmodule

/* File: logic/ucp_ir_codec.sv */
// Infrared pulse encoder and receive conditioning for one channel
`timescale 1ns/1ps
module ucp_ir_codec (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic tx_bit_in,
   input  wire logic rx_pin_in,
   input  wire logic invert_in,
   output logic      ir_tx_out,
   output logic      ir_rx_out
);
   import ucp_pkg::*;
   // -----------------------------------------------------------------
   // Encoder: each one-to-zero step of the transmit bit yields a short high pulse, idle is low
   // -----------------------------------------------------------------
   logic [3:0] pcnt_ff;   // Remaining pulse cycles
   logic       prev_ff;   // Last transmit bit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pcnt_ff <= '0;
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= tx_bit_in;
         if (prev_ff && !tx_bit_in) begin
            pcnt_ff <= 4'(IR_PULSE_CYC);
         end else if (pcnt_ff != 4'h0) begin
            pcnt_ff <= pcnt_ff - 4'h1;
         end
      end
   end
   assign ir_tx_out = (pcnt_ff != 4'h0);
   // -----------------------------------------------------------------
   // Decoder: optional polarity flip, pulse high becomes data zero
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ir_rx_out <= 1'b1;
      end else begin
         ir_rx_out <= ~(rx_pin_in ^ invert_in);
      end
   end
endmodule

/* File: verification/ucp_line_model.sv */
// Far-side model: serial line and modem lines of both channels
`timescale 1ns/1ps
module ucp_line_model
   import ucp_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ir_mode_in,   // Far end sends infrared pulses
   input  wire logic       pulse_in,     // Line carries a mark pulse
   input  wire logic [3:0] modem_cmd_in, // Levels for cts, dsr, cd, ri
   output logic            line_a_out,
   output logic            line_b_out,
   output ucp_modem_in_s   modem_a_out,
   output ucp_modem_in_s   modem_b_out
);
   // ------------------------------------------------------------
   // Receive lines
   // ------------------------------------------------------------
   // Line A: standard idle is high, infrared idles low and pulses high; line B stays high
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         line_a_out <= 1'b1;
         line_b_out <= 1'b1;
      end else begin
         line_a_out <= ir_mode_in ? pulse_in : ~pulse_in;
         line_b_out <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Modem lines
   // ------------------------------------------------------------
   // Channel B lines are left inactive, as if tied high
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         modem_a_out <= ucp_modem_in_s'(4'hf);
         modem_b_out <= ucp_modem_in_s'(4'hf);
      end else begin
         modem_a_out <= ucp_modem_in_s'(modem_cmd_in);
         modem_b_out <= ucp_modem_in_s'(4'hf);
      end
   end
endmodule

/* File: verification/uart_channel_pin_functions_bench.sv */
// Self-checking bench for the two-channel pin logic
`timescale 1ns/1ps
module uart_channel_pin_functions_bench;
   import ucp_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int TXT = 4;  // Free slots for transmit ready
   localparam int RXT = 2;  // Bytes for receive ready
   logic          clk_in = 1'b0;
   logic          rst_n_in, cs_n_in, channel_select_in, wr_in;
   logic [2:0]    addr_in;
   logic [7:0]    wdata_in;
   logic [15:0]   baud_div_in;
   ucp_core_s     core_a_in, core_b_in;
   ucp_modem_in_s modem_a, modem_b, gp_a, gp_b;
   logic          line_a, line_b, ir_mode, pulse;
   logic [3:0]    modem_cmd;
   logic          irq_a, irq_b, txr_a, txr_b, so_a, so_b, rxd_a, rxd_b;
   logic          rts_a, rts_b, dtr_a, dtr_b, mf_a, mf_b;
   logic          ta_a, ta_b, ci_a, ci_b;
   int            n_fail = 0;
   int            compares = 0;
   int            n;
   logic          prev;

   always #25 clk_in = ~clk_in;  // 20 MHz

   ucp_top #(.TX_THRESH(TXT), .RX_THRESH(RXT), .DIV_W(16)) u_ucp_top (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
      .channel_select_in(channel_select_in), .wr_in(wr_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .baud_div_in(baud_div_in),
      .core_a_in(core_a_in), .core_b_in(core_b_in),
      .modem_a_in(modem_a), .modem_b_in(modem_b),
      .serial_in_a(line_a), .serial_in_b(line_b),
      .irq_out_a(irq_a), .irq_out_b(irq_b),
      .tx_ready_n_a(txr_a), .tx_ready_n_b(txr_b),
      .serial_out_a(so_a), .serial_out_b(so_b),
      .rx_data_a_out(rxd_a), .rx_data_b_out(rxd_b),
      .request_to_send_n_a(rts_a), .request_to_send_n_b(rts_b),
      .terminal_ready_n_a(dtr_a), .terminal_ready_n_b(dtr_b),
      .multi_function_out_a(mf_a), .multi_function_out_b(mf_b),
      .tx_allow_a_out(ta_a), .tx_allow_b_out(ta_b),
      .cts_irq_a_out(ci_a), .cts_irq_b_out(ci_b),
      .gpio_in_a_out(gp_a), .gpio_in_b_out(gp_b));

   ucp_line_model u_ucp_line_model (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ir_mode_in(ir_mode),
      .pulse_in(pulse), .modem_cmd_in(modem_cmd),
      .line_a_out(line_a), .line_b_out(line_b),
      .modem_a_out(modem_a), .modem_b_out(modem_b));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One write; the strobe drops at the edge that takes it
   task automatic wr_reg(input logic ch, input logic [2:0] a,
                         input logic [7:0] d);
      @(posedge clk_in);
      cs_n_in <= 1'b0;
      wr_in <= 1'b1;
      channel_select_in <= ch;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      cs_n_in <= 1'b1;
      wr_in <= 1'b0;
   endtask
   // Receive path trails by three edges (line, decoder, pin flop);
   // look mid-cycle once every stage has settled
   task automatic settle;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_status;
      @(posedge clk_in);
      core_a_in.irq_pend <= 1'b1;
      core_a_in.tx_level <= 8'(TXT - 1);
      core_b_in.tx_level <= 8'(TXT);
      settle();
      chk(irq_a, 1'b1);
      chk(irq_b, 1'b0);
      chk(txr_a, 1'b1);
      chk(txr_b, 1'b0);
      @(posedge clk_in);
      core_a_in.irq_pend <= 1'b0;
      settle();
      chk(irq_a, 1'b0);
   endtask
   task automatic t_mf;
      wr_reg(1'b1, IDX_MCR, 8'h08);
      settle();
      chk(mf_a, 1'b0);
      wr_reg(1'b1, IDX_MCR, 8'h00);
      wr_reg(1'b1, 3'h7, 8'hff);  // Unmapped index must be ignored
      settle();
      chk(mf_a, 1'b1);
      wr_reg(1'b1, IDX_AFR, 8'h02);
      settle();
      n = 0;
      prev = mf_a;
      // Divisor 4: a 16x period of 4 clocks, 8 edges in 16 clocks
      repeat (16) begin
         @(negedge clk_in);
         if (mf_a !== prev) n++;
         prev = mf_a;
      end
      chk(8'(n), 8'h08);
      wr_reg(1'b1, IDX_AFR, 8'h04);
      settle();
      chk(mf_a, 1'b1);
      @(posedge clk_in);
      core_a_in.rx_level <= 8'(RXT);
      settle();
      chk(mf_a, 1'b0);
      wr_reg(1'b1, IDX_AFR, 8'h00);
   endtask
   task automatic t_chan;
      wr_reg(1'b0, IDX_MCR, 8'h08);
      settle();
      chk({mf_a, mf_b}, 2'b10);
      wr_reg(1'b0, IDX_MCR, 8'h00);
      wr_reg(1'b1, IDX_AFR, 8'h01);
      wr_reg(1'b0, IDX_MCR, 8'h08);
      settle();
      chk({mf_a, mf_b}, 2'b00);
      wr_reg(1'b1, IDX_MCR, 8'h00);
      settle();
      chk({mf_a, mf_b}, 2'b11);
      wr_reg(1'b1, IDX_AFR, 8'h00);
   endtask
   task automatic t_ir;
      chk({so_a, rxd_a}, 2'b11);
      wr_reg(1'b1, IDX_MCR, 8'h40);
      ir_mode <= 1'b1;
      settle();
      chk({so_a, rxd_a}, 2'b01);
      @(posedge clk_in);
      core_a_in.tx_bit <= 1'b0;
      n = 0;
      repeat (8) begin
         @(negedge clk_in);
         if (so_a === 1'b1) n++;
      end
      chk(8'(n), 8'(IR_PULSE_CYC));
      @(posedge clk_in);
      pulse <= 1'b1;
      settle();
      chk(rxd_a, 1'b0);
      @(posedge clk_in);
      pulse <= 1'b0;
      wr_reg(1'b1, IDX_FEATURE_CONTROL_REG, 8'h04);
      settle();
      chk(rxd_a, 1'b0);
      wr_reg(1'b1, IDX_FEATURE_CONTROL_REG, 8'h00);
      wr_reg(1'b1, IDX_MCR, 8'h00);
      ir_mode <= 1'b0;
      core_a_in.tx_bit <= 1'b1;
      settle();
      chk(so_a, 1'b1);
   endtask
   task automatic t_modem;
      wr_reg(1'b1, IDX_MCR, 8'h03);  // Assert RTS and DTR first
      modem_cmd <= 4'h5;
      settle();
      chk({rts_a, dtr_a}, 2'b00);
      chk(gp_a, 4'h5);
      // Channel B stays at reset settings and idle lines
      chk({rxd_b, rts_b, dtr_b, ta_b, ci_b}, 5'b11110);
      chk(gp_b, 4'hf);
      wr_reg(1'b1, IDX_EFR, 8'h80);
      wr_reg(1'b1, IDX_IER, 8'h80);
      settle();
      chk({ta_a, ci_a}, 2'b10);
      @(posedge clk_in);
      modem_cmd <= 4'hd;
      settle();
      chk({ta_a, ci_a}, 2'b01);
      wr_reg(1'b1, IDX_FEATURE_CONTROL_REG, 8'h08);
      core_a_in.tx_busy <= 1'b1;
      settle();
      chk(rts_a, 1'b0);
      @(posedge clk_in);
      core_a_in.tx_busy <= 1'b0;
      settle();
      chk(rts_a, 1'b1);
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      cs_n_in = 1'b1;
      wr_in = 1'b0;
      channel_select_in = 1'b1;
      addr_in = 3'h0;
      wdata_in = 8'h00;
      baud_div_in = 16'h0004;
      core_a_in = '{1'b0, 8'h00, 8'h00, 1'b0, 1'b1};
      core_b_in = '{1'b0, 8'h00, 8'h00, 1'b0, 1'b1};
      ir_mode = 1'b0;
      pulse = 1'b0;
      modem_cmd = 4'hf;
      repeat (7) @(posedge clk_in);
      @(negedge clk_in);
      chk({so_a, so_b, mf_a, irq_a}, 4'he);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_status();
      t_mf();
      t_chan();
      t_ir();
      t_modem();
      wrap_up();
   end
   // Whole run is under two hundred clocks; cut off far beyond that
   initial begin
      #(50 * 5000);
      n_fail++;
      wrap_up();
   end
endmodule
